// File: src/bpp_pkg.sv
// constants and types shared by the buffered page program sequencer
//==============================================================
package bpp_pkg;
	//==============================================================
	// opcodes
	localparam logic [7:0] OP_COMMIT_B1 = 8'h88;
	localparam logic [7:0] OP_COMMIT_B2 = 8'h89;
	localparam logic [7:0] OP_THRU_B1 = 8'h82;
	localparam logic [7:0] OP_THRU_B2 = 8'h85;
	localparam logic [7:0] OP_BYTE_B1 = 8'h02;
	//==============================================================
	// geometry and field positions
	localparam int PAGE_W = 12;
	localparam int OFS_W = 9;
	localparam int BUF_DEPTH = 264;
	localparam logic [8:0] SIZE_264 = 9'h108;
	localparam logic [8:0] SIZE_256 = 9'h100;
	localparam int PAGE_LSB_264 = 9;
	localparam int PAGE_LSB_256 = 8;
	localparam logic [2:0] DATA_BYTE_IDX = 3'h4;
	localparam logic [2:0] LAST_ADDR_IDX = 3'h3;
	localparam logic [2:0] LAST_BIT = 3'h7;
	//==============================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ERASE = 3'b010,
		ST_PROG = 3'b100
	} bpp_state_t;
	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_COMMIT = 2'h1,
		CMD_THRU = 2'h2,
		CMD_BYTE = 2'h3
	} bpp_cmd_t;
	typedef struct packed {
		logic req;
		logic erase;
		logic [PAGE_W-1:0] page;
		logic [OFS_W-1:0] offset;
		logic [7:0] data;
	} bpp_arr_req_t;
	typedef struct packed {
		logic ack;
		logic fail;
	} bpp_arr_rsp_t;
endpackage : bpp_pkg

// File: src/bpp_sequencer.sv
// spi command capture, two page buffers and the self-timed program walk
module bpp_sequencer
	import bpp_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic cs_n_in,
	input wire logic sck_in,
	input wire logic si_in,
	input wire logic page_256_in,
	input wire bpp_arr_rsp_t arr_rsp_in,
	output bpp_arr_req_t arr_req_out,
	output logic busy_out,
	output logic erase_program_error_flag_out
);
	//==============================================================
	// decode helpers
	function automatic bpp_cmd_t cmd_of(input logic [7:0] op);
		case (op)
			OP_COMMIT_B1, OP_COMMIT_B2: cmd_of = CMD_COMMIT;
			OP_THRU_B1, OP_THRU_B2: cmd_of = CMD_THRU;
			OP_BYTE_B1: cmd_of = CMD_BYTE;
			default: cmd_of = CMD_NONE;
		endcase
	endfunction : cmd_of

	function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a, input logic m256);
		if (m256) begin
			page_of = a[PAGE_LSB_256 +: PAGE_W];
		end else begin
			page_of = a[PAGE_LSB_264 +: PAGE_W];
		end
	endfunction : page_of

	function automatic logic [OFS_W-1:0] ofs_of(input logic [23:0] a, input logic m256);
		if (m256) begin
			ofs_of = {1'b0, a[7:0]};
		end else begin
			ofs_of = a[OFS_W-1:0];
		end
	endfunction : ofs_of

	//==============================================================
	// pin synchronisers
	logic [2:0] cs_sync_q;
	logic [2:0] sck_sync_q;
	logic [1:0] si_sync_q;
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			cs_sync_q <= 3'h7;
			sck_sync_q <= 3'h0;
			si_sync_q <= 2'h0;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], cs_n_in};
			sck_sync_q <= {sck_sync_q[1:0], sck_in};
			si_sync_q <= {si_sync_q[0], si_in};
		end
	end

	logic cs_rise;
	logic sck_rise;
	assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
	assign sck_rise = ~cs_sync_q[1] & sck_sync_q[1] & ~sck_sync_q[2];

	//==============================================================
	// command capture and buffer load
	logic [6:0] sh_q, sh_d;
	logic [2:0] bit_q, bit_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] op_q, op_d;
	logic [23:0] addr_q, addr_d;
	logic [OFS_W-1:0] ptr_q, ptr_d;
	logic [BUF_DEPTH-1:0] mask_q, mask_d;
	logic [7:0] buf_q [2][BUF_DEPTH];
	logic [7:0] buf_d [2][BUF_DEPTH];
	logic launch_q, launch_d;
	bpp_cmd_t lcmd_q, lcmd_d;
	logic wr_now;
	logic busy_q, busy_d;
	bpp_state_t state_q, state_d;

	always_comb begin
		logic [7:0] byte_in;
		logic [8:0] sz;
		byte_in = {sh_q, si_sync_q[1]};
		sz = page_256_in ? SIZE_256 : SIZE_264;
		sh_d = sh_q;
		bit_d = bit_q;
		cnt_d = cnt_q;
		op_d = op_q;
		addr_d = addr_q;
		ptr_d = ptr_q;
		mask_d = mask_q;
		buf_d = buf_q;
		launch_d = 1'b0;
		lcmd_d = lcmd_q;
		wr_now = 1'b0;
		if (cs_sync_q[1]) begin
			bit_d = 3'h0;
			cnt_d = 3'h0;
		end else if (sck_rise) begin
			sh_d = byte_in[6:0];
			bit_d = bit_q + 3'h1;
			if (bit_q == LAST_BIT) begin
				if (cnt_q == 3'h0) begin
					op_d = byte_in;
					if (!busy_q && cmd_of(byte_in) == CMD_BYTE) begin
						mask_d = '0;
					end
				end else if (cnt_q <= LAST_ADDR_IDX) begin
					addr_d = {addr_q[15:0], byte_in};
					ptr_d = ofs_of({addr_q[15:0], byte_in}, page_256_in);
				end
				if (cnt_q >= DATA_BYTE_IDX) begin
					// a commit opcode carries no data; stray bytes are dropped
					if (!busy_q && (cmd_of(op_q) == CMD_THRU || cmd_of(op_q) == CMD_BYTE)) begin
						wr_now = 1'b1;
						buf_d[op_q == OP_THRU_B2][ptr_q] = byte_in;
						mask_d[ptr_q] = 1'b1;
						ptr_d = (ptr_q == sz - 9'h1) ? '0 : ptr_q + 9'h1;
					end
				end else begin
					cnt_d = cnt_q + 3'h1;
				end
			end
		end
		if (cs_rise && !busy_q && cnt_q >= DATA_BYTE_IDX && cmd_of(op_q) != CMD_NONE) begin
			// cut byte only aborts the byte program
			if (!(cmd_of(op_q) == CMD_BYTE && bit_q != 3'h0)) begin
				launch_d = 1'b1;
				lcmd_d = cmd_of(op_q);
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			sh_q <= '0;
			bit_q <= '0;
			cnt_q <= '0;
			op_q <= '0;
			addr_q <= '0;
			ptr_q <= '0;
			mask_q <= '0;
			launch_q <= 1'b0;
			lcmd_q <= CMD_NONE;
		end else begin
			sh_q <= sh_d;
			bit_q <= bit_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			addr_q <= addr_d;
			ptr_q <= ptr_d;
			mask_q <= mask_d;
			launch_q <= launch_d;
			lcmd_q <= lcmd_d;
		end
	end

	// buffer contents are undefined until written, so no reset
	always_ff @(posedge clk_sys_in) begin
		buf_q <= buf_d;
	end

	//==============================================================
	// self-timed erase and program walk
	logic [OFS_W-1:0] idx_q, idx_d;
	logic [8:0] size_q, size_d;
	logic sel_q, sel_d;
	logic full_q, full_d;
	logic epe_q, epe_d;
	bpp_arr_req_t req_q, req_d;

	always_comb begin
		logic last;
		last = (idx_q == size_q - 9'h1);
		state_d = state_q;
		idx_d = idx_q;
		size_d = size_q;
		sel_d = sel_q;
		full_d = full_q;
		epe_d = epe_q;
		req_d = req_q;
		case (state_q)
			ST_IDLE: begin
				if (launch_q) begin
					epe_d = 1'b0;
					size_d = page_256_in ? SIZE_256 : SIZE_264;
					sel_d = (op_q == OP_COMMIT_B2 || op_q == OP_THRU_B2);
					full_d = (lcmd_q != CMD_BYTE);
					idx_d = '0;
					req_d.page = page_of(addr_q, page_256_in);
					req_d.offset = '0;
					req_d.data = 8'hFF;
					if (lcmd_q == CMD_THRU) begin
						state_d = ST_ERASE;
						req_d.req = 1'b1;
						req_d.erase = 1'b1;
					end else begin
						state_d = ST_PROG;
						req_d.req = 1'b0;
						req_d.erase = 1'b0;
					end
				end
			end
			ST_ERASE: begin
				if (arr_rsp_in.ack) begin
					epe_d = epe_q | arr_rsp_in.fail;
					req_d.req = 1'b0;
					req_d.erase = 1'b0;
					state_d = ST_PROG;
				end
			end
			ST_PROG: begin
				if (req_q.req) begin
					if (arr_rsp_in.ack) begin
						epe_d = epe_q | arr_rsp_in.fail;
						req_d.req = 1'b0;
						idx_d = idx_q + 9'h1;
						if (last) begin
							state_d = ST_IDLE;
						end
					end
				end else if (full_q || mask_q[idx_q]) begin
					req_d.req = 1'b1;
					req_d.offset = idx_q;
					req_d.data = buf_q[sel_q][idx_q];
				end else begin
					// skipped bytes cost one cycle, far below a byte program
					idx_d = idx_q + 9'h1;
					if (last) begin
						state_d = ST_IDLE;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
				req_d.req = 1'b0;
			end
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			state_q <= ST_IDLE;
			idx_q <= '0;
			size_q <= SIZE_264;
			sel_q <= 1'b0;
			full_q <= 1'b0;
			epe_q <= 1'b0;
			busy_q <= 1'b0;
			req_q <= '0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			size_q <= size_d;
			sel_q <= sel_d;
			full_q <= full_d;
			epe_q <= epe_d;
			busy_q <= busy_d;
			req_q <= req_d;
		end
	end

	assign arr_req_out = req_q;
	assign busy_out = busy_q;
	assign erase_program_error_flag_out = epe_q;

	//==============================================================
	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	sequence s_thru_launch;
		launch_q && lcmd_q == CMD_THRU && state_q == ST_IDLE;
	endsequence
	sequence s_erase_done;
		state_q == ST_ERASE && arr_rsp_in.ack;
	endsequence
	// the erase ack lands many cycles after launch, so the erase step alone starts the check
	property p_erase_then_prog;
		s_erase_done |=> state_q == ST_PROG && busy_q && !req_q.erase && !req_q.req;
	endproperty

	a_erase_first_req: assert property (s_thru_launch |=> req_q.req && req_q.erase && busy_q)
		else $error("erase not issued first");
	a_erase_then_prog: assert property (p_erase_then_prog)
		else $error("program did not follow erase");
	a_commit_no_erase: assert property (launch_q && lcmd_q == CMD_COMMIT && state_q == ST_IDLE
		|=> state_q == ST_PROG && !req_q.erase && busy_q)
		else $error("commit started wrongly");
	a_epe_on_fail: assert property (state_q != ST_IDLE && arr_rsp_in.ack && arr_rsp_in.fail
		|=> erase_program_error_flag_out)
		else $error("error flag not set");
	a_partial_abort: assert property (cs_rise && cmd_of(op_q) == CMD_BYTE && bit_q != 3'h0
		|=> !launch_q)
		else $error("partial byte launched");
	a_busy_ignore: assert property (busy_q && cs_rise |=> !launch_q)
		else $error("command taken while busy");
	a_byte_buf_one: assert property (req_q.req && !req_q.erase && !full_q |-> !sel_q)
		else $error("byte program used buffer 2");
	a_skip_unsent: assert property (state_q == ST_PROG && !req_q.req && !full_q
		&& !mask_q[idx_q] |=> !req_q.req)
		else $error("unsent byte programmed");
	a_buffer_wrap: assert property (wr_now && ptr_q == (page_256_in ? SIZE_256 : SIZE_264) - 9'h1
		|=> ptr_q == '0)
		else $error("buffer pointer did not wrap");
endmodule : bpp_sequencer

// File: bench/bpp_array_model.sv
// array partner: acks each request lat_in+1 cycles after it rises and logs it
module bpp_array_model
	import bpp_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic clr_in,
	input wire logic fail_in,
	input wire logic [7:0] lat_in,
	input wire bpp_arr_req_t req_in,
	output bpp_arr_rsp_t rsp_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int n_prog;
	int n_erase;
	int w;
	logic order;
	logic [11:0] page;
	logic [8:0] seen [0:263];
	//==============================================================
	// slow lat_in keeps the device busy for long spans
	always @(posedge clk_sys_in) begin
		rsp_out <= '0;
		w <= 0;
		if (clr_in) begin
			n_prog <= 0;
			n_erase <= 0;
			order <= 1'b0;
			foreach (seen[i]) seen[i] <= 9'h000;
		end else if (req_in.req && !rsp_out.ack) begin
			w <= w + 1;
			if (w >= int'(lat_in)) begin
				w <= 0;
				rsp_out <= {1'b1, fail_in};
				page <= req_in.page;
				if (req_in.erase) begin
					n_erase <= n_erase + 1;
					order <= (n_prog == 0);
				end else begin
					n_prog <= n_prog + 1;
					seen[req_in.offset] <= {1'b1, req_in.data};
				end
			end
		end
	end
endmodule : bpp_array_model

// File: bench/testbench.sv
// self-checking bench: spi frames in, array partner logs the writes
module testbench
	import bpp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic cs_n = 1'b1;
	logic sck = 1'b0;
	logic si = 1'b0;
	logic m256 = 1'b0;
	logic clr = 1'b1;
	logic fail = 1'b0;
	logic [7:0] lat = 8'h01;
	bpp_arr_rsp_t rsp;
	bpp_arr_req_t req;
	logic busy;
	logic err;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int c;
	always #5 clk_sys_in = ~clk_sys_in;
	bpp_sequencer i_bpp_sequencer (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.cs_n_in(cs_n), .sck_in(sck), .si_in(si), .page_256_in(m256), .arr_rsp_in(rsp),
		.arr_req_out(req), .busy_out(busy), .erase_program_error_flag_out(err));
	bpp_array_model i_bpp_array_model (.clk_sys_in(clk_sys_in), .clr_in(clr),
		.fail_in(fail), .lat_in(lat), .req_in(req), .rsp_out(rsp));
	//==============================================================
	// compare and spi tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	task automatic chk_ops(input int np, input int ne, input logic [11:0] pg);
		chk("progs", np, i_bpp_array_model.n_prog);
		chk("erases", ne, i_bpp_array_model.n_erase);
		chk("order", ne, 32'(i_bpp_array_model.order));
		chk("page", 32'(pg), 32'(i_bpp_array_model.page));
	endtask : chk_ops
	task automatic chk_byte(input int o, input logic [7:0] d);
		chk("byte", {23'h0, 1'b1, d}, 32'(i_bpp_array_model.seen[o]));
	endtask : chk_byte
	// sck halves of 4 clk keep above the synchroniser's 3 clk minimum
	task automatic sbit(input logic v);
		si <= v;
		repeat (4) @(posedge clk_sys_in);
		sck <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		sck <= 1'b0;
	endtask : sbit
	task automatic sbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) sbit(b[i]);
	endtask : sbyte
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n,
		input logic [7:0] d, input int xb);
		@(posedge clk_sys_in);
		cs_n <= 1'b0;
		sbyte(op);
		sbyte(a[23:16]);
		sbyte(a[15:8]);
		sbyte(a[7:0]);
		for (int i = 0; i < n; i++) sbyte(d + 8'(i));
		for (int i = 0; i < xb; i++) sbit(1'b1);
		repeat (4) @(posedge clk_sys_in);
		cs_n <= 1'b1;
		repeat (6) @(posedge clk_sys_in);
	endtask : frame
	task automatic log_clr();
		@(posedge clk_sys_in);
		clr <= 1'b1;
		@(posedge clk_sys_in);
		clr <= 1'b0;
	endtask : log_clr
	// samples on the falling edge, clear of the outputs' update
	task automatic wait_done();
		c = 0;
		while (busy !== 1'b1 && c < 20) begin
			@(negedge clk_sys_in);
			c++;
		end
		chk("busy_on", 1, 32'(busy));
		c = 0;
		while (busy !== 1'b0 && c < 20000) begin
			@(negedge clk_sys_in);
			c++;
		end
		chk("busy_off", 0, 32'(busy));
	endtask : wait_done
	task automatic results();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	//==============================================================
	// scenarios
	task automatic t_thru();
		log_clr();
		frame(OP_THRU_B1, {3'h0, 12'h5A3, 9'h106}, 3, 8'hA0, 0);
		wait_done();
		chk_ops(264, 1, 12'h5A3);
		chk_byte(262, 8'hA0);
		chk_byte(0, 8'hA2);
		log_clr();
		m256 <= 1'b1;
		frame(OP_THRU_B2, {4'h0, 12'h123, 8'hFF}, 2, 8'hB0, 0);
		wait_done();
		chk_ops(256, 1, 12'h123);
		chk_byte(0, 8'hB1);
		$display("thru done");
	endtask : t_thru
	task automatic t_commit();
		log_clr();
		frame(OP_COMMIT_B2, {4'h0, 12'h123, 8'h5A}, 0, 8'h00, 0);
		wait_done();
		chk_ops(256, 0, 12'h123);
		chk_byte(255, 8'hB0);
		log_clr();
		m256 <= 1'b0;
		frame(OP_COMMIT_B1, {3'h0, 12'h5A3, 9'h1FF}, 0, 8'h00, 0);
		wait_done();
		chk_ops(264, 0, 12'h5A3);
		chk_byte(263, 8'hA1);
		$display("commit done");
	endtask : t_commit
	task automatic t_byte();
		log_clr();
		frame(OP_BYTE_B1, {3'h0, 12'h7FF, 9'h0FF}, 2, 8'hC0, 0);
		wait_done();
		chk_ops(2, 0, 12'h7FF);
		chk_byte(256, 8'hC1);
		log_clr();
		frame(OP_COMMIT_B2, {3'h0, 12'h7FE, 9'h000}, 0, 8'h00, 0);
		wait_done();
		chk_byte(255, 8'hB0);
		log_clr();
		m256 <= 1'b1;
		frame(OP_BYTE_B1, {4'h0, 12'h0FF, 8'hFF}, 2, 8'hD0, 0);
		wait_done();
		chk_ops(2, 0, 12'h0FF);
		chk_byte(0, 8'hD1);
		log_clr();
		m256 <= 1'b0;
		frame(OP_BYTE_B1, {3'h0, 12'h010, 9'h000}, 1, 8'hE0, 3);
		repeat (20) @(negedge clk_sys_in);
		chk("busy_cut", 0, 32'(busy));
		chk("progs_cut", 0, i_bpp_array_model.n_prog);
		$display("byte done");
	endtask : t_byte
	task automatic t_busy_err();
		log_clr();
		lat <= 8'h14;
		fail <= 1'b1;
		frame(OP_COMMIT_B1, {3'h0, 12'h001, 9'h000}, 0, 8'h00, 0);
		frame(OP_BYTE_B1, {3'h0, 12'h002, 9'h000}, 1, 8'hE0, 0);
		wait_done();
		chk_ops(264, 0, 12'h001);
		chk("error", 1, 32'(err));
		log_clr();
		lat <= 8'h01;
		frame(OP_THRU_B1, {3'h0, 12'h004, 9'h000}, 1, 8'h11, 0);
		wait_done();
		chk("error", 1, 32'(err));
		log_clr();
		fail <= 1'b0;
		frame(OP_COMMIT_B1, {3'h0, 12'h004, 9'h000}, 0, 8'h00, 0);
		wait_done();
		chk("error", 0, 32'(err));
		$display("busy_err done");
	endtask : t_busy_err
	//==============================================================
	// main sequence and hang guard
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		clr <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		t_thru();
		t_commit();
		t_byte();
		t_busy_err();
		results();
	end
endmodule : testbench
